// ==== hdl/fdcmd_top.sv ====
// The Avalon-MM interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`include "fdcmd_defs.svh"
// Summary of operation
// - Version answers one byte, bits 7,4 set
// - Write data takes nine ordered bytes
// - Write execution forwards host data to drive
// - Write results: three status, then C,H,R,N
// - Write deleted behaves like write data
// - Format: six bytes, four ID bytes per sector
// - Recalibrate steps to track 0, interrupts
// - Sense interrupt returns status and cylinder, or 80h alone if none pending
// - Seek steps head to target cylinder
// - Unknown opcode returns single byte 80h
module fdcmd_top
  import fdcmd_pkg::*;
#(
  parameter int STEP_UNIT_CYC = `FDC_STEP_UNIT_US * 1000 / `FDC_CLK_NS
) (
  input  wire logic          clk_sys,
  input  wire logic          rst_b,
  input  wire fdcmd_av_req_t av_req,
  output logic [31:0]        av_readdata,
  output logic               av_waitrequest,
  output logic               irq,
  input  wire logic          drv_at_track0,
  output logic [1:0]         drv_sel,
  output logic               drv_head,
  output logic               drv_dir,
  output logic               drv_step,
  output logic [7:0]         drv_wdata,
  output logic               drv_wstrobe
);

  // ========================================================
  // Helpers
  function automatic fdcmd_op_t op_decode(input logic [7:0] b);
    fdcmd_op_t o;
    o = OP_BAD;
    if (b == `FDC_OPC_VER) o = OP_VER;
    else if ((b & `FDC_MASK_RW) == `FDC_OPC_WR) o = OP_WR;
    else if ((b & `FDC_MASK_RW) == `FDC_OPC_WDEL) o = OP_WDEL;
    else if ((b & `FDC_MASK_FMT) == `FDC_OPC_FMT) o = OP_FMT;
    else if (b == `FDC_OPC_RCL) o = OP_RCL;
    else if (b == `FDC_OPC_SNS) o = OP_SNS;
    else if (b == `FDC_OPC_SPC) o = OP_SPC;
    else if (b == `FDC_OPC_SEEK) o = OP_SEEK;
    return o;
  endfunction

  function automatic logic [3:0] op_len(input fdcmd_op_t o);
    logic [3:0] n;
    case (o)
      OP_WR, OP_WDEL: n = `FDC_LEN_RW;
      OP_FMT:         n = `FDC_LEN_FMT;
      OP_RCL:         n = `FDC_LEN_RCL;
      OP_SPC, OP_SEEK: n = `FDC_LEN_THREE;
      default:        n = `FDC_LEN_ONE;
    endcase
    return n;
  endfunction

  // Size code zero means the data length limit gives the count
  function automatic logic [15:0] sec_bytes(input logic [7:0] n,
                                            input logic [7:0] data_length_limit);
    logic [15:0] r;
    if (n == 8'h00) r = {8'h00, data_length_limit};
    else if (n > 8'h07) r = `FDC_SEC_MAX;
    else r = `FDC_SEC_BASE << n[2:0];
    return r;
  endfunction

  // ========================================================
  // Reset and pin synchronisers
  logic [1:0] rst_pipe;
  logic       rst_core_b;
  logic       t0_meta;
  logic       t0_sync;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) rst_pipe <= 2'h0;
    else rst_pipe <= {rst_pipe[0], 1'b1};
  end
  assign rst_core_b = rst_pipe[1];

  always_ff @(posedge clk_sys or negedge rst_core_b) begin
    if (!rst_core_b) begin
      t0_meta <= 1'b0;
      t0_sync <= 1'b0;
    end else begin
      t0_meta <= drv_at_track0;
      t0_sync <= t0_meta;
    end
  end

  // ========================================================
  // Avalon slave: one wait state on every access
  logic ack;
  wire  req     = av_req.read | av_req.write;
  wire  wr_fire = av_req.write & ack;
  wire  rd_fire = av_req.read & ack;
  wire  sel_data = av_req.address == `FDC_OFS_DATA;
  wire  sel_stat = av_req.address == `FDC_OFS_STAT;
  wire  sel_ists = av_req.address == `FDC_OFS_ISTS;
  wire  sel_iclr = av_req.address == `FDC_OFS_ICLR;
  wire  sel_ien  = av_req.address == `FDC_OFS_IEN;
  wire  sel_spec = av_req.address == `FDC_OFS_SPEC;
  wire  [7:0] wbyte = av_req.writedata[7:0];
  assign av_waitrequest = req & ~ack;

  // ========================================================
  // Sequencer state
  fdcmd_state_t        state;
  fdcmd_op_t           op_q;
  logic [7:0]          cmd_buf [0:8];
  logic [3:0]          cmd_cnt;
  logic [7:0]          res_buf [0:6];
  logic [2:0]          res_cnt;
  logic [2:0]          res_idx;
  logic [15:0]         bytes_left;
  logic [7:0]          rec;
  logic [7:0]          target;
  logic [7:0]          present_cylinder [0:3];
  logic [23:0]         step_tmr;
  logic                int_pend;
  logic [7:0]          int_st0;
  logic [7:0]          int_pcn;
  logic [3:0]          step_rate_time;
  logic [3:0]          head_unload_time;
  logic [6:0]          head_load_time;
  logic                non_dma;
  logic [`FDC_IRQ_W-1:0] ev;
  logic [`FDC_IRQ_W-1:0] ists;
  logic [`FDC_IRQ_W-1:0] ien;

  wire data_wr = wr_fire & sel_data;
  wire data_rd = rd_fire & sel_data;
  wire fdcmd_op_t op_now = (cmd_cnt == 4'h0) ? op_decode(wbyte) : op_q;
  wire cmd_last = (cmd_cnt + 4'h1) == op_len(op_now);
  wire [1:0] dsel = cmd_buf[`FDC_B_DRV][1:0];
  wire hsel = cmd_buf[`FDC_B_DRV][`FDC_HEAD_BIT];
  wire [7:0] pcn_cur = present_cylinder[dsel];
  wire [7:0] st0_norm = {5'h00, hsel, dsel};
  wire [4:0] srt_units = {1'b0, ~step_rate_time} + 5'h01;
  wire [23:0] step_cyc = 24'(int'(srt_units) * STEP_UNIT_CYC);
  wire xfer_end = (op_q == OP_FMT) || (rec >= cmd_buf[`FDC_B_EOT]);
  wire step_done = (op_q == OP_RCL) ? t0_sync : (pcn_cur == target);
  wire [7:0] next_pcn = (op_q == OP_RCL || pcn_cur > target) ?
                        pcn_cur - 8'h01 : pcn_cur + 8'h01;

  // ========================================================
  // Command, execution and result phases
  always_ff @(posedge clk_sys or negedge rst_core_b) begin
    if (!rst_core_b) begin
      state <= FS_CMD;
      op_q <= OP_BAD;
      for (int i = 0; i < 9; i++) cmd_buf[i] <= 8'h00;
      for (int i = 0; i < 7; i++) res_buf[i] <= 8'h00;
      for (int i = 0; i < 4; i++) present_cylinder[i] <= 8'h00;
      cmd_cnt <= 4'h0;
      res_cnt <= 3'h0;
      res_idx <= 3'h0;
      bytes_left <= 16'h0000;
      rec <= 8'h00;
      target <= 8'h00;
      step_tmr <= 24'h000000;
      int_pend <= 1'b0;
      int_st0 <= 8'h00;
      int_pcn <= 8'h00;
      step_rate_time <= 4'h0;
      head_unload_time <= 4'h0;
      head_load_time <= 7'h00;
      non_dma <= 1'b0;
      ev <= '0;
      drv_sel <= 2'h0;
      drv_head <= 1'b0;
      drv_dir <= 1'b0;
      drv_step <= 1'b0;
      drv_wdata <= 8'h00;
      drv_wstrobe <= 1'b0;
    end else begin
      ev <= '0;
      drv_step <= 1'b0;
      drv_wstrobe <= 1'b0;
      case (state)
        FS_CMD: begin
          if (data_wr) begin
            cmd_buf[cmd_cnt] <= wbyte;
            if (cmd_cnt == 4'h0) op_q <= op_decode(wbyte);
            if (cmd_last) begin
              cmd_cnt <= 4'h0;
              state <= FS_DISP;
            end else begin
              cmd_cnt <= cmd_cnt + 4'h1;
            end
          end
        end
        FS_DISP: begin
          drv_sel <= dsel;
          drv_head <= hsel;
          res_idx <= 3'h0;
          state <= FS_RES;
          ev[`FDC_IRQ_RES] <= 1'b1;
          case (op_q)
            OP_VER: begin
              res_buf[0] <= `FDC_VER_RESULT;
              res_cnt <= `FDC_RES_ONE;
            end
            OP_WR, OP_WDEL: begin
              rec <= cmd_buf[`FDC_B_REC];
              bytes_left <= sec_bytes(cmd_buf[`FDC_B_SIZE],
                                      cmd_buf[`FDC_B_DTL]);
              state <= FS_XFER;
              ev[`FDC_IRQ_RES] <= 1'b0;
            end
            OP_FMT: begin
              bytes_left <= {6'h00, cmd_buf[`FDC_B_FSC], 2'h0};
              state <= FS_XFER;
              ev[`FDC_IRQ_RES] <= 1'b0;
            end
            OP_RCL, OP_SEEK: begin
              drv_head <= (op_q == OP_SEEK) & hsel;
              target <= (op_q == OP_SEEK) ? cmd_buf[`FDC_B_NCN] : 8'h00;
              step_tmr <= 24'h000000;
              state <= FS_STEP;
              ev[`FDC_IRQ_RES] <= 1'b0;
            end
            OP_SNS: begin
              int_pend <= 1'b0;
              res_buf[0] <= int_pend ? int_st0 : `FDC_ST0_INVALID;
              res_buf[1] <= int_pcn;
              res_cnt <= int_pend ? `FDC_RES_SNS : `FDC_RES_ONE;
            end
            OP_SPC: begin
              step_rate_time <= cmd_buf[`FDC_B_SRT][7:4];
              head_unload_time <= cmd_buf[`FDC_B_SRT][3:0];
              head_load_time <= cmd_buf[`FDC_B_HLT][7:1];
              non_dma <= cmd_buf[`FDC_B_HLT][0];
              state <= FS_CMD;
              ev[`FDC_IRQ_RES] <= 1'b0;
            end
            default: begin
              res_buf[0] <= `FDC_ST0_INVALID;
              res_cnt <= `FDC_RES_ONE;
              ev[`FDC_IRQ_BAD] <= 1'b1;
            end
          endcase
        end
        FS_XFER: begin
          if (data_wr) begin
            drv_wdata <= wbyte;
            drv_wstrobe <= 1'b1;
            if (bytes_left > 16'h0001) begin
              bytes_left <= bytes_left - 16'h0001;
            end else if (!xfer_end) begin
              rec <= rec + 8'h01;
              bytes_left <= sec_bytes(cmd_buf[`FDC_B_SIZE],
                                      cmd_buf[`FDC_B_DTL]);
            end else begin
              res_buf[0] <= st0_norm;
              res_buf[1] <= 8'h00;
              res_buf[2] <= 8'h00;
              res_buf[3] <= (op_q == OP_FMT) ? 8'h00 : cmd_buf[`FDC_B_CYL];
              res_buf[4] <= (op_q == OP_FMT) ? 8'h00 : cmd_buf[`FDC_B_HEAD];
              res_buf[5] <= (op_q == OP_FMT) ? 8'h00 : rec;
              res_buf[6] <= (op_q == OP_FMT) ? 8'h00 : cmd_buf[`FDC_B_SIZE];
              res_cnt <= `FDC_RES_RW;
              state <= FS_RES;
              ev[`FDC_IRQ_RES] <= 1'b1;
            end
          end
        end
        FS_STEP: begin
          if (step_done) begin
            if (op_q == OP_RCL) present_cylinder[dsel] <= 8'h00;
            int_pend <= 1'b1;
            int_st0 <= `FDC_ST0_SEEK_END | st0_norm;
            int_pcn <= (op_q == OP_RCL) ? 8'h00 : pcn_cur;
            ev[`FDC_IRQ_SEEK] <= 1'b1;
            state <= FS_CMD;
          end else if (step_tmr != 24'h000000) begin
            step_tmr <= step_tmr - 24'h000001;
          end else begin
            drv_dir <= (op_q != OP_RCL) && (pcn_cur < target);
            drv_step <= 1'b1;
            present_cylinder[dsel] <= next_pcn;
            step_tmr <= step_cyc;
          end
        end
        FS_RES: begin
          if (data_rd) begin
            if (res_idx + 3'h1 == res_cnt) begin
              res_idx <= 3'h0;
              state <= FS_CMD;
            end else begin
              res_idx <= res_idx + 3'h1;
            end
          end
        end
        default: state <= FS_CMD;
      endcase
    end
  end

  // ========================================================
  // Interrupt status, enable and clear
  wire [`FDC_IRQ_W-1:0] iclr = (wr_fire & sel_iclr) ?
                               av_req.writedata[`FDC_IRQ_W-1:0] : '0;

  // Set beats clear so an event in the clear cycle is kept
  always_ff @(posedge clk_sys or negedge rst_core_b) begin
    if (!rst_core_b) begin
      ists <= '0;
      ien <= '0;
    end else begin
      ists <= (ists & ~iclr) | ev;
      if (wr_fire & sel_ien) ien <= av_req.writedata[`FDC_IRQ_W-1:0];
    end
  end
  assign irq = |(ists & ien);

  // ========================================================
  // Read data, sampled in the wait cycle
  wire busy = (state != FS_CMD) || (cmd_cnt != 4'h0);
  wire [7:0] res_byte = (state == FS_RES) ? res_buf[res_idx] : 8'h00;
  wire [31:0] stat_word = {16'h0000, pcn_cur, 3'h0, non_dma,
                           state == FS_STEP, state == FS_XFER,
                           state == FS_RES, busy};
  wire [31:0] rd_mux =
    sel_data ? {24'h000000, res_byte} :
    sel_stat ? stat_word :
    sel_ists ? {{(32-`FDC_IRQ_W){1'b0}}, ists} :
    sel_ien  ? {{(32-`FDC_IRQ_W){1'b0}}, ien} :
    sel_spec ? {16'h0000, step_rate_time, head_unload_time, head_load_time, non_dma} : 32'h00000000;

  always_ff @(posedge clk_sys or negedge rst_core_b) begin
    if (!rst_core_b) begin
      ack <= 1'b0;
      av_readdata <= 32'h00000000;
    end else begin
      ack <= req & ~ack;
      if (req & ~ack) av_readdata <= rd_mux;
    end
  end

endmodule

// ==== shared/fdcmd_defs.svh ====
`ifndef FDCMD_DEFS_SVH
`define FDCMD_DEFS_SVH
// ==========================================================
// Register byte offsets
`define FDC_OFS_DATA     5'h00
`define FDC_OFS_STAT     5'h04
`define FDC_OFS_ISTS     5'h08
`define FDC_OFS_ICLR     5'h0C
`define FDC_OFS_IEN      5'h10
`define FDC_OFS_SPEC     5'h14
// ==========================================================
// Interrupt bit positions
`define FDC_IRQ_SEEK     0
`define FDC_IRQ_RES      1
`define FDC_IRQ_BAD      2
`define FDC_IRQ_W        3
// ==========================================================
// Opcodes and opcode masks
`define FDC_MASK_RW      8'h3F
`define FDC_MASK_FMT     8'hBF
`define FDC_OPC_VER      8'h10
`define FDC_OPC_WR       8'h05
`define FDC_OPC_WDEL     8'h09
`define FDC_OPC_FMT      8'h0D
`define FDC_OPC_RCL      8'h07
`define FDC_OPC_SNS      8'h08
`define FDC_OPC_SPC      8'h03
`define FDC_OPC_SEEK     8'h0F
// ==========================================================
// Command lengths in bytes
`define FDC_LEN_ONE      4'h1
`define FDC_LEN_RCL      4'h2
`define FDC_LEN_THREE    4'h3
`define FDC_LEN_FMT      4'h6
`define FDC_LEN_RW       4'h9
// ==========================================================
// Result lengths and values
`define FDC_RES_ONE      3'h1
`define FDC_RES_SNS      3'h2
`define FDC_RES_RW       3'h7
`define FDC_VER_RESULT   8'h90
`define FDC_ST0_INVALID  8'h80
`define FDC_ST0_SEEK_END 8'h20
// ==========================================================
// Command byte positions and bits
`define FDC_B_DRV        1
`define FDC_B_CYL        2
`define FDC_B_HEAD       3
`define FDC_B_REC        4
`define FDC_B_SIZE       5
`define FDC_B_EOT        6
`define FDC_B_DTL        8
`define FDC_B_FSC        3
`define FDC_B_NCN        2
`define FDC_B_SRT        1
`define FDC_B_HLT        2
`define FDC_HEAD_BIT     2
// ==========================================================
// Timing and sector sizes
`define FDC_STEP_UNIT_US 1000
`define FDC_CLK_NS       10
`define FDC_SEC_BASE     16'h0080
`define FDC_SEC_MAX      16'h4000
`endif

// ==== shared/fdcmd_pkg.sv ====
package fdcmd_pkg;
  typedef enum logic [4:0] {
    FS_CMD  = 5'b00001,
    FS_DISP = 5'b00010,
    FS_XFER = 5'b00100,
    FS_STEP = 5'b01000,
    FS_RES  = 5'b10000
  } fdcmd_state_t;
  typedef enum logic [3:0] {
    OP_BAD, OP_VER, OP_WR, OP_WDEL, OP_FMT,
    OP_RCL, OP_SNS, OP_SPC, OP_SEEK
  } fdcmd_op_t;
  typedef struct packed {
    logic        read;
    logic        write;
    logic [4:0]  address;
    logic [31:0] writedata;
  } fdcmd_av_req_t;
endpackage

// ==== tb/fdcmd_drive_model.sv ====
`timescale 1ns/1ps
module fdcmd_drive_model (
  input wire logic        clk_sys,
  input wire logic        rst_b,
  input wire logic        drv_step,
  input wire logic        drv_dir,
  input wire logic        drv_wstrobe,
  input wire logic [7:0]  drv_wdata,
  output logic            drv_at_track0
);
  // ==========
  // Head position and captured sector bytes
  logic [7:0] cyl;
  logic [7:0] wbuf [0:15];
  int         n_wr;
  // Head starts off track 0 so a recalibrate has real work to do
  assign drv_at_track0 = (cyl == 8'h00);
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cyl <= 8'h03;
      n_wr <= 0;
    end else begin
      if (drv_step) begin
        cyl <= drv_dir ? cyl + 8'h01 : cyl - 8'h01;
      end
      if (drv_wstrobe) begin
        wbuf[n_wr[3:0]] <= drv_wdata;
        n_wr <= n_wr + 1;
      end
    end
  end
endmodule

// ==== tb/fdcmd_properties.sv ====
`timescale 1ns/1ps
`include "fdcmd_defs.svh"
module fdcmd_checker
  import fdcmd_pkg::*;
#(
  parameter int STEP_UNIT_CYC = 4
) (
  input wire logic          clk_sys,
  input wire logic          rst_b,
  input wire fdcmd_av_req_t av_req,
  input wire logic [31:0]   av_readdata,
  input wire logic          av_waitrequest,
  input wire logic          irq,
  input wire logic          drv_at_track0,
  input wire logic [1:0]    drv_sel,
  input wire logic          drv_head,
  input wire logic          drv_dir,
  input wire logic          drv_step,
  input wire logic [7:0]    drv_wdata,
  input wire logic          drv_wstrobe
);
  // ==========
  // Bus handshake, drive pulses and interrupt masking
  wire req;
  assign req = av_req.read | av_req.write;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  wait_first_a: assert property (req && !$past(req) |-> av_waitrequest)
    else $error("no wait state on first request cycle");
  wait_one_a: assert property (req && av_waitrequest |=> !av_waitrequest)
    else $error("request not answered after one wait state");
  wait_idle_a: assert property (!req |-> !av_waitrequest)
    else $error("waitrequest high without a request");
  step_pulse_a: assert property (drv_step |=> !drv_step)
    else $error("step pulse longer than one cycle");
  strobe_pulse_a: assert property (drv_wstrobe |=> !drv_wstrobe)
    else $error("write strobe longer than one cycle");
  ien_zero_a: assert property (av_req.write && !av_waitrequest &&
      av_req.address == `FDC_OFS_IEN && av_req.writedata[3:0] == 4'h0
      |=> !irq)
    else $error("interrupt high with all sources disabled");
  unmapped_zero_a: assert property (av_req.read && !av_waitrequest &&
      av_req.address > `FDC_OFS_SPEC |-> av_readdata == 32'h0)
    else $error("unmapped read not zero");
  reset_quiet_a: assert property ($rose(rst_b) |-> !irq && !drv_step &&
      !drv_wstrobe && av_readdata == 32'h0)
    else $error("outputs active right after reset");
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`include "fdcmd_defs.svh"
module tb
  import fdcmd_pkg::*;
;
  logic          clk_sys;
  logic          rst_b;
  fdcmd_av_req_t av_req;
  logic [31:0]   av_readdata;
  logic [31:0]   q;
  logic          av_waitrequest;
  logic          irq;
  logic          drv_at_track0;
  logic [1:0]    drv_sel;
  logic          drv_head;
  logic          drv_dir;
  logic          drv_step;
  logic [7:0]    drv_wdata;
  logic          drv_wstrobe;
  logic [16:0]   seed;
  logic [7:0]    b1;
  logic [7:0]    b2;
  logic [7:0]    cy;
  int            n_fail;
  int            n_compared;

  fdcmd_top #(.STEP_UNIT_CYC(4)) i_dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .av_req(av_req),
    .av_readdata(av_readdata), .av_waitrequest(av_waitrequest),
    .irq(irq), .drv_at_track0(drv_at_track0), .drv_sel(drv_sel),
    .drv_head(drv_head), .drv_dir(drv_dir), .drv_step(drv_step),
    .drv_wdata(drv_wdata), .drv_wstrobe(drv_wstrobe));
  fdcmd_drive_model i_drv (
    .clk_sys(clk_sys), .rst_b(rst_b), .drv_step(drv_step),
    .drv_dir(drv_dir), .drv_wstrobe(drv_wstrobe), .drv_wdata(drv_wdata),
    .drv_at_track0(drv_at_track0));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ==========
  // Helpers
  function automatic logic [7:0] rnd();
    seed = {seed[15:0], seed[16] ^ seed[13]};
    return seed[7:0];
  endfunction
  function automatic logic known(input logic [7:0] b);
    return (b & 8'h3F) == 8'h05 || (b & 8'h3F) == 8'h09 ||
      (b & 8'hBF) == 8'h0D || b inside {8'h10, 8'h07, 8'h08, 8'h03, 8'h0F};
  endfunction
  task automatic wrap_up();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    av_req <= '{read: !w, write: w, address: a, writedata: d};
    // Look at waitrequest on the rising edge, where the slave takes it
    do begin
      @(posedge clk_sys);
      n++;
    end while (av_waitrequest !== 1'b0 && n < 20);
    if (av_waitrequest !== 1'b0) begin
      n_fail++;
      wrap_up();
    end
    q = av_readdata;
    av_req <= '0;
  endtask
  task automatic put(input logic [7:0] b);
    bus(1'b1, `FDC_OFS_DATA, {24'h0, b});
  endtask
  task automatic res(input string nm, input logic [7:0] e);
    bus(1'b0, `FDC_OFS_DATA, 32'h0);
    chk(nm, {24'h0, e}, q);
  endtask
  task automatic wait_ists(input int b);
    int n;
    n = 0;
    do begin
      bus(1'b0, `FDC_OFS_ISTS, 32'h0);
      n++;
    end while (q[b] !== 1'b1 && n < 100);
    chk("event bit", 32'h1 << b, q & (32'h1 << b));
    if (q[b] !== 1'b1) wrap_up();
  endtask
  task automatic clr();
    bus(1'b1, `FDC_OFS_ICLR, 32'hF);
  endtask
  task automatic run_cmd(input logic [7:0] c [$], input int nx,
                         input logic [7:0] r [$]);
    logic [7:0] d [$];
    int         base;
    base = i_drv.n_wr;
    foreach (c[i]) put(c[i]);
    for (int i = 0; i < nx; i++) begin
      d.push_back(rnd());
      put(d[i]);
    end
    wait_ists(`FDC_IRQ_RES);
    foreach (d[i]) chk("drive byte", d[i], i_drv.wbuf[(base + i) % 16]);
    foreach (r[i]) res("result byte", r[i]);
    clr();
  endtask

  // ==========
  // Scenarios
  initial begin
    repeat (50000) @(posedge clk_sys);
    n_fail++;
    wrap_up();
  end
  initial begin
    av_req = '0;
    rst_b = 1'b0;
    n_fail = 0;
    n_compared = 0;
    seed = 17'h16179;
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    bus(1'b0, `FDC_OFS_IEN, 32'h0);
    chk("enable reset", 32'h0, q);
    bus(1'b1, 5'h18, 32'hFFFF);
    bus(1'b0, 5'h18, 32'h0);
    chk("unmapped", 32'h0, q);
    bus(1'b1, `FDC_OFS_IEN, 32'hF);
    put(8'h10);
    wait_ists(`FDC_IRQ_RES);
    chk("irq raised", 32'h1, {31'h0, irq});
    bus(1'b0, `FDC_OFS_STAT, 32'h0);
    chk("result phase", 32'h3, q & 32'h3);
    res("version", 8'h90);
    clr();
    @(negedge clk_sys);
    chk("irq cleared", 32'h0, {31'h0, irq});
    repeat (3) begin
      do b1 = rnd(); while (known(b1));
      put(b1);
      wait_ists(`FDC_IRQ_BAD);
      res("invalid", 8'h80);
      clr();
    end
    b1 = rnd();
    b1[7:4] = 4'hF;
    b2 = rnd();
    put(8'h03);
    put(b1);
    put(b2);
    bus(1'b0, `FDC_OFS_SPEC, 32'h0);
    chk("specify", {16'h0, b1, b2}, q);
    bus(1'b0, `FDC_OFS_STAT, 32'h0);
    chk("non_dma", {31'h0, b2[0]}, {31'h0, q[4]});
    put(8'h07);
    repeat (20) @(posedge clk_sys);
    chk("early step", 32'h3, {24'h0, i_drv.cyl});
    put(8'h02);
    wait_ists(`FDC_IRQ_SEEK);
    chk("track zero", 32'h0, {24'h0, i_drv.cyl});
    chk("drive sel", 32'h2, {30'h0, drv_sel});
    put(8'h08);
    res("sense st0", 8'h22);
    res("sense pcn", 8'h00);
    clr();
    repeat (2) begin
      // The model keeps one head, so seeks stay on the recalibrated drive
      b1 = (rnd() & 8'h04) | 8'h02;
      cy = (rnd() & 8'h0F) + 8'h01;
      put(8'h0F);
      put(b1);
      put(cy);
      wait_ists(`FDC_IRQ_SEEK);
      chk("cylinder", {24'h0, cy}, {24'h0, i_drv.cyl});
      chk("head", {31'h0, b1[2]}, {31'h0, drv_head});
      put(8'h08);
      res("sense st0", 8'h20 | b1);
      res("sense pcn", cy);
      clr();
    end
    put(8'h08);
    res("no pending", 8'h80);
    clr();
    for (int k = 0; k < 2; k++) begin
      b1 = (k == 0 ? 8'h05 : 8'h09) | (rnd() & 8'hC0);
      b2 = rnd() & 8'h07;
      cy = rnd();
      run_cmd('{b1, b2, cy, {7'h0, b2[2]}, 8'h01, 8'h00, 8'h02, rnd(),
        8'h04}, 8, '{b2, 8'h00, 8'h00, cy, {7'h0, b2[2]}, 8'h02,
        8'h00});
    end
    b2 = rnd() & 8'h07;
    run_cmd('{8'h0D | (rnd() & 8'h40), b2, 8'h00, 8'h02, rnd(), rnd()}, 8,
      '{b2, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
    bus(1'b1, `FDC_OFS_IEN, 32'h0);
    put(8'h10);
    wait_ists(`FDC_IRQ_RES);
    chk("irq masked", 32'h0, {31'h0, irq});
    res("version", 8'h90);
    clr();
    wrap_up();
  end
endmodule

bind fdcmd_top fdcmd_checker #(.STEP_UNIT_CYC(STEP_UNIT_CYC)) i_chk (
  .clk_sys(clk_sys), .rst_b(rst_b), .av_req(av_req),
  .av_readdata(av_readdata), .av_waitrequest(av_waitrequest), .irq(irq),
  .drv_at_track0(drv_at_track0), .drv_sel(drv_sel), .drv_head(drv_head),
  .drv_dir(drv_dir), .drv_step(drv_step), .drv_wdata(drv_wdata),
  .drv_wstrobe(drv_wstrobe));
